// *** rtl/epbd_decoder.sv ***
// External port address decoder, bank select and fetch checker
`timescale 1ns/1ps
`include "epbd_consts.svh"
module epbd_decoder
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire epbd_pkg::epbd_req_type req,
	input wire epbd_pkg::epbd_cfg_type cfg,
	input wire logic remote_req,
	input wire logic proc_id,
	input wire logic [47:0] fetch_word,
	output logic [3:0] dram_bank_select,
	output logic [3:0] async_bank_select,
	output logic [1:0] bank_index,
	output logic [31:0] bank_offset,
	output logic [15:0] bank_timing,
	output logic [31:0] dram_timing_out,
	output logic simd_wide,
	output logic [63:0] external_port_data_bus,
	output logic [47:0] comp_instr,
	output logic [1:0] comp_count,
	output logic bus_request,
	output logic fetch_fault,
	output logic decode_miss,
	output logic cfg_error
);
	logic local_grant;
	logic [3:0] hit;
	logic [3:0] next_hit;
	logic [31:0] next_offset;
	logic [1:0] next_index;
	logic fetch_ok;

	// Window test used for every bank and fetch range
	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// Base of a bank: same in either mode, so partial devices leave holes
	function automatic logic [31:0] bank_base(input logic [1:0] b);
		unique case (b)
			2'h0: bank_base = `EPBD_ASYNC_B0_LO;
			2'h1: bank_base = `EPBD_ASYNC_B1_LO;
			2'h2: bank_base = `EPBD_ASYNC_B2_LO;
			2'h3: bank_base = `EPBD_ASYNC_B3_LO;
		endcase
	endfunction

	// Per-bank window check in normal-word units; each bank picks its own mode
	always_comb
	begin
		next_hit = 4'h0;
		next_hit[0] = cfg.dram_mode[0] ? in_range(req.addr, `EPBD_DRAM_B0_LO, `EPBD_DRAM_B0_HI)
			: in_range(req.addr, `EPBD_ASYNC_B0_LO, `EPBD_ASYNC_B0_HI);
		next_hit[1] = cfg.dram_mode[1] ? in_range(req.addr, `EPBD_ASYNC_B1_LO, `EPBD_DRAM_B1_HI)
			: in_range(req.addr, `EPBD_ASYNC_B1_LO, `EPBD_ASYNC_B1_HI);
		next_hit[2] = cfg.dram_mode[2] ? in_range(req.addr, `EPBD_ASYNC_B2_LO, `EPBD_DRAM_B2_HI)
			: in_range(req.addr, `EPBD_ASYNC_B2_LO, `EPBD_ASYNC_B2_HI);
		next_hit[3] = cfg.dram_mode[3] ? in_range(req.addr, `EPBD_ASYNC_B3_LO, `EPBD_DRAM_B3_HI)
			: in_range(req.addr, `EPBD_ASYNC_B3_LO, `EPBD_ASYNC_B3_HI);
		next_index = next_hit[1] ? 2'h1 : next_hit[2] ? 2'h2 : next_hit[3] ? 2'h3 : 2'h0;
		next_offset = req.addr - bank_base(next_index);
	end

	// Fetches live only in bank 0, in their own format's range
	always_comb
	begin
		unique case (req.kind)
			epbd_pkg::EPBD_FETCH_FULL:
				fetch_ok = in_range(req.addr, `EPBD_FULL_FETCH_LO, `EPBD_FULL_FETCH_HI);
			epbd_pkg::EPBD_FETCH_COMP:
				fetch_ok = in_range(req.addr, `EPBD_COMP_FETCH_LO, `EPBD_COMP_FETCH_HI);
			default:
				fetch_ok = 1'b1;
		endcase
	end

	// Gap addresses and refused fetches select nothing
	assign hit = (req.valid && fetch_ok) ? next_hit : 4'h0;

	// Shared DRAM bus arbitration between two chips
	epbd_arbiter u_arbiter
	(
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.local_req(req.valid && |(hit & cfg.dram_mode)),
		.remote_req(remote_req),
		.rotate(cfg.rotate),
		.lock(cfg.lock),
		.timeout(cfg.timeout),
		.proc_id(proc_id),
		.local_grant(local_grant)
	);

	// Bank selects registered; DRAM ones wait for the bus grant
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			dram_bank_select <= 4'h0;
			async_bank_select <= 4'h0;
			bank_index <= 2'h0;
			bank_offset <= 32'h0000_0000;
			decode_miss <= 1'b0;
			fetch_fault <= 1'b0;
			bus_request <= 1'b0;
		end
		else
		begin
			dram_bank_select <= local_grant ? (hit & cfg.dram_mode) : 4'h0;
			async_bank_select <= hit & ~cfg.dram_mode;
			bank_index <= next_index;
			bank_offset <= next_offset;
			decode_miss <= req.valid && (next_hit == 4'h0);
			fetch_fault <= req.valid && !fetch_ok;
			bus_request <= |(hit & cfg.dram_mode); // Demand shown a cycle late
		end
	end

	// Timing of the selected bank: async per bank, DRAM shared
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			bank_timing <= 16'h0000;
			dram_timing_out <= 32'h0000_0000;
		end
		else
		begin
			bank_timing <= cfg.async_timing[next_index];
			dram_timing_out <= cfg.dram_timing;
		end
	end

	// Sanity of software settings: size, device, clock ratio
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			cfg_error <= 1'b0;
		else
		begin
			cfg_error <= (cfg.clk_ratio < `EPBD_RATIO_MIN)
				|| (cfg.dev_mbit > `EPBD_DEV_MBIT_MAX)
				|| (cfg.dram_size_mb[next_index] < `EPBD_DRAM_MB_MIN)
				|| (cfg.dram_size_mb[next_index] > `EPBD_DRAM_MB_MAX);
		end
	end

	// SIMD puts both elements on the 64-bit bus: low word primary
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			simd_wide <= 1'b0;
			external_port_data_bus <= 64'h0000_0000_0000_0000;
		end
		else
		begin
			simd_wide <= req.valid && req.simd && |(next_hit & cfg.dram_mode);
			external_port_data_bus <= req.simd ? req.wdata : {32'h0000_0000, req.wdata[31:0]};
		end
	end

	// A compressed fetch word carries up to three 16-bit instructions
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			comp_instr <= 48'h0000_0000_0000;
			comp_count <= 2'h0;
		end
		else
		begin
			comp_instr <= fetch_word;
			comp_count <= (req.valid && req.kind == epbd_pkg::EPBD_FETCH_COMP && fetch_ok)
				? 2'h3 : 2'h0;
		end
	end

	// Nothing selected in an async gap such as just above bank 1
	property p_gap_no_select;
		@(posedge sys_clk) disable iff (sys_rst)
		(req.valid && !cfg.dram_mode[1] && req.addr == 32'h0440_0000)
		|=> (async_bank_select == 4'h0 && dram_bank_select == 4'h0);
	endproperty
	a_gap_no_select: assert property (p_gap_no_select) else $error("gap address selected a bank");

	// Async bank 1 chosen at its base
	property p_async_b1;
		@(posedge sys_clk) disable iff (sys_rst)
		(req.valid && !cfg.dram_mode[1] && req.kind == epbd_pkg::EPBD_DATA
			&& req.addr == 32'h0400_0000) |=> async_bank_select == 4'h2;
	endproperty
	a_async_b1: assert property (p_async_b1) else $error("async bank 1 not selected");

	// Async bank 0 ends below 4M words
	property p_async_b0_end;
		@(posedge sys_clk) disable iff (sys_rst)
		(req.valid && !cfg.dram_mode[0] && req.addr == 32'h0040_0000) |=> !async_bank_select[0];
	endproperty
	a_async_b0_end: assert property (p_async_b0_end) else $error("bank 0 window too large");

	// DRAM bank 0 reaches its top address
	property p_dram_b0;
		@(posedge sys_clk) disable iff (sys_rst)
		(req.valid && cfg.dram_mode[0] && req.kind == epbd_pkg::EPBD_DATA
			&& req.addr == 32'h03FF_FFFF) |=> bank_index == 2'h0 && !decode_miss;
	endproperty
	a_dram_b0: assert property (p_dram_b0) else $error("dram bank 0 top missed");

	// DRAM bank 3 covers its last word
	property p_dram_b3;
		@(posedge sys_clk) disable iff (sys_rst)
		(req.valid && cfg.dram_mode[3] && req.addr == 32'h0FFF_FFFF) |=> bank_index == 2'h3;
	endproperty
	a_dram_b3: assert property (p_dram_b3) else $error("dram bank 3 top missed");

	// Fetch outside bank 0 is refused
	property p_fetch_bank0;
		@(posedge sys_clk) disable iff (sys_rst)
		(req.valid && req.kind != epbd_pkg::EPBD_DATA && req.addr[31:26] != 6'h00)
		|=> fetch_fault && async_bank_select == 4'h0;
	endproperty
	a_fetch_bank0: assert property (p_fetch_bank0) else $error("fetch outside bank 0 taken");

	// Compressed fetch in range yields three instructions
	property p_comp_three;
		@(posedge sys_clk) disable iff (sys_rst)
		(req.valid && req.kind == epbd_pkg::EPBD_FETCH_COMP && req.addr == 32'h0060_0000)
		|=> comp_count == 2'h3 && !fetch_fault;
	endproperty
	a_comp_three: assert property (p_comp_three) else $error("compressed fetch refused");

	// Full-length fetch stops above its range
	property p_full_end;
		@(posedge sys_clk) disable iff (sys_rst)
		(req.valid && req.kind == epbd_pkg::EPBD_FETCH_FULL && req.addr == 32'h0060_0000)
		|=> fetch_fault;
	endproperty
	a_full_end: assert property (p_full_end) else $error("full fetch beyond range");

	// Clock ratio below two flagged
	property p_ratio;
		@(posedge sys_clk) disable iff (sys_rst)
		(cfg.clk_ratio == 4'h1) |=> cfg_error;
	endproperty
	a_ratio: assert property (p_ratio) else $error("dram clock ratio not flagged");

	// Async bank 2 reaches its last word
	property p_async_b2_top;
		@(posedge sys_clk) disable iff (sys_rst)
		(req.valid && !cfg.dram_mode[2] && req.kind == epbd_pkg::EPBD_DATA
			&& req.addr == `EPBD_ASYNC_B2_HI) |=> async_bank_select == 4'h4;
	endproperty
	a_async_b2_top: assert property (p_async_b2_top) else $error("async bank 2 top missed");

	// Offset counts from the fixed base even at the top of bank 1
	property p_b1_offset;
		@(posedge sys_clk) disable iff (sys_rst)
		(req.valid && !cfg.dram_mode[1] && req.addr == `EPBD_ASYNC_B1_HI)
		|=> bank_offset == (`EPBD_ASYNC_B1_HI - `EPBD_ASYNC_B1_LO);
	endproperty
	a_b1_offset: assert property (p_b1_offset) else $error("bank 1 offset wrong");

	// DRAM bank 1 starts at the async base
	property p_dram_b1;
		@(posedge sys_clk) disable iff (sys_rst)
		(req.valid && cfg.dram_mode[1] && req.addr == `EPBD_ASYNC_B1_LO)
		|=> bank_index == 2'h1 && !decode_miss;
	endproperty
	a_dram_b1: assert property (p_dram_b1) else $error("dram bank 1 base missed");

	// No DRAM select without the bus grant
	property p_grant_gate;
		@(posedge sys_clk) disable iff (sys_rst)
		!local_grant |=> dram_bank_select == 4'h0;
	endproperty
	a_grant_gate: assert property (p_grant_gate) else $error("dram select without grant");

	// At most one DRAM chip select at a time
	property p_dram_onehot;
		@(posedge sys_clk) disable iff (sys_rst)
		1'b1 |-> $onehot0(dram_bank_select);
	endproperty
	a_dram_onehot: assert property (p_dram_onehot) else $error("two dram selects");

	// SIMD with no DRAM bank configured stays narrow
	property p_simd_async;
		@(posedge sys_clk) disable iff (sys_rst)
		(req.valid && req.simd && cfg.dram_mode == 4'h0) |=> !simd_wide;
	endproperty
	a_simd_async: assert property (p_simd_async) else $error("simd on async bank");

	// Compressed fetch stops above its range
	property p_comp_end;
		@(posedge sys_clk) disable iff (sys_rst)
		(req.valid && req.kind == epbd_pkg::EPBD_FETCH_COMP
			&& req.addr == `EPBD_COMP_FETCH_HI + 32'h0000_0001) |=> fetch_fault;
	endproperty
	a_comp_end: assert property (p_comp_end) else $error("compressed fetch beyond range");
endmodule

// *** rtl/epbd_consts.svh ***
// Address map and sizing constants for the external port bank decoder
`ifndef EPBD_CONSTS_SVH
`define EPBD_CONSTS_SVH
`define EPBD_ASYNC_B0_LO 32'h0020_0000
`define EPBD_ASYNC_B0_HI 32'h003F_FFFF
`define EPBD_ASYNC_B1_LO 32'h0400_0000
`define EPBD_ASYNC_B1_HI 32'h043F_FFFF
`define EPBD_ASYNC_B2_LO 32'h0800_0000
`define EPBD_ASYNC_B2_HI 32'h083F_FFFF
`define EPBD_ASYNC_B3_LO 32'h0C00_0000
`define EPBD_ASYNC_B3_HI 32'h0C3F_FFFF
`define EPBD_DRAM_B0_LO 32'h0020_0000
`define EPBD_DRAM_B0_HI 32'h03FF_FFFF
`define EPBD_DRAM_B1_HI 32'h07FF_FFFF
`define EPBD_DRAM_B2_HI 32'h0BFF_FFFF
`define EPBD_DRAM_B3_HI 32'h0FFF_FFFF
`define EPBD_FULL_FETCH_LO 32'h0020_0000
`define EPBD_FULL_FETCH_HI 32'h005F_FFFF
`define EPBD_COMP_FETCH_LO 32'h0060_0000
`define EPBD_COMP_FETCH_HI 32'h00FF_FFFF
`define EPBD_DRAM_MB_MIN 9'h020
`define EPBD_DRAM_MB_MAX 9'h100
`define EPBD_DEV_MBIT_MAX 12'h800
`define EPBD_TOUT_RESET 16'h00FF
`define EPBD_RATIO_MIN 4'h2
`endif

// *** rtl/epbd_pkg.sv ***
// Types shared by the external port bank decoder
package epbd_pkg;
	typedef enum logic [1:0] {EPBD_DATA, EPBD_FETCH_FULL, EPBD_FETCH_COMP} epbd_kind_type;
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		epbd_kind_type kind;
		logic simd;
		logic write;
		logic [63:0] wdata;
	} epbd_req_type;
	typedef struct packed {
		logic [3:0] dram_mode;
		logic [3:0][8:0] dram_size_mb;
		logic [11:0] dev_mbit;
		logic [3:0][15:0] async_timing;
		logic [31:0] dram_timing;
		logic [3:0] clk_ratio;
		logic rotate;
		logic [15:0] timeout;
		logic lock;
	} epbd_cfg_type;
endpackage

// *** rtl/epbd_arbiter.sv ***
// Two-processor shared external bus arbiter with rotation, time-out and lock
`timescale 1ns/1ps
`include "epbd_consts.svh"
module epbd_arbiter
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic local_req,
	input wire logic remote_req,
	input wire logic rotate,
	input wire logic lock,
	input wire logic [15:0] timeout,
	input wire logic proc_id,
	output logic local_grant
);
	logic owner;
	logic owned;
	logic [15:0] hold_cnt;
	logic next_owner;
	logic next_owned;
	logic last_winner;

	// Both chips run this same logic, so they reach one verdict without glue
	always_comb
	begin
		next_owner = owner;
		next_owned = owned;
		if (owned && !lock && (hold_cnt >= timeout ||
			!(owner == proc_id ? local_req : remote_req)))
			next_owned = 1'b0;
		if (!next_owned && (local_req || remote_req))
		begin
			next_owned = 1'b1;
			if (local_req && remote_req)
				next_owner = rotate ? ~last_winner : 1'b0; // Fixed: id 0 wins
			else
				next_owner = local_req ? proc_id : ~proc_id;
		end
	end

	// Grant follows this cycle's verdict, so a lone request selects on the next edge
	assign local_grant = next_owned && (next_owner == proc_id);

	// Ownership and tenure counter; lock keeps the bus past the time-out
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			owner <= 1'b0;
			owned <= 1'b0;
			hold_cnt <= 16'h0000;
			last_winner <= 1'b1;
		end
		else
		begin
			owner <= next_owner;
			owned <= next_owned;
			if (next_owned && !owned)
				last_winner <= next_owner;
			hold_cnt <= (next_owned && owned && next_owner == owner) ? hold_cnt + 16'h0001 : 16'h0000;
		end
	end
endmodule

// *** test/epbd_remote_proc.sv ***
// Model of the second processor that competes for the shared DRAM bus
`timescale 1ns/1ps
module epbd_remote_proc
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic enable,
	output logic remote_req
);
	logic [31:0] rnd;
	logic [2:0] hold;

	// Holds its request for a random span, then always drops for a cycle so
	// the local side gets a turn; only this one remote party shares the bus
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			rnd <= 32'h1357_9BDF;
			remote_req <= 1'h0;
			hold <= 3'h0;
		end
		else
		begin
			rnd <= {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
			if (remote_req)
			begin
				hold <= hold - 3'h1;
				remote_req <= hold != 3'h0;
			end
			else
			begin
				remote_req <= enable && rnd[0];
				hold <= rnd[3:1];
			end
		end
	end
endmodule

// *** test/external_port_bank_decoder_tb.sv ***
// Self-checking bench for the external port bank decoder
`timescale 1ns/1ps
`include "epbd_consts.svh"
module external_port_bank_decoder_tb;
	logic sys_clk;
	logic sys_rst;
	epbd_pkg::epbd_req_type req;
	epbd_pkg::epbd_cfg_type cfg;
	logic remote_req;
	logic part_en;
	logic [47:0] fetch_word;
	logic [3:0] dram_bank_select, async_bank_select;
	logic [1:0] bank_index, comp_count;
	logic [31:0] bank_offset, dram_timing_out, seed;
	logic [15:0] bank_timing;
	logic [63:0] external_port_data_bus;
	logic [47:0] comp_instr;
	logic simd_wide, fetch_fault, decode_miss, cfg_error, bus_request;
	logic [31:0] corner [16] = '{32'h001F_FFFF, 32'h0020_0000, 32'h003F_FFFF, 32'h0040_0000,
		32'h03FF_FFFF, 32'h0400_0000, 32'h043F_FFFF, 32'h0440_0000, 32'h0C3F_FFFF,
		32'h0FFF_FFFF, 32'h1000_0000, 32'h005F_FFFF, 32'h0060_0000, 32'h00FF_FFFF,
		32'h0100_0000, 32'h083F_FFFF};
	int n_errors;
	int num_checks;

	epbd_decoder dut (.sys_clk, .sys_rst, .req, .cfg, .remote_req, .proc_id(1'h0), .fetch_word,
		.dram_bank_select, .async_bank_select, .bank_index, .bank_offset, .bank_timing,
		.dram_timing_out, .simd_wide, .external_port_data_bus, .comp_instr, .comp_count,
		.bus_request, .fetch_fault, .decode_miss, .cfg_error);
	epbd_remote_proc partner (.sys_clk, .sys_rst, .enable(part_en), .remote_req);

	initial
	begin
		sys_clk = 1'h0;
		forever #4 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'h0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0);
	endfunction

	// Expected {hit, dram, fault, bank} from the fixed bank map
	function automatic logic [4:0] decode(input logic [31:0] a, input logic [3:0] m,
		input logic [1:0] k);
		logic [1:0] b;
		logic hit;
		logic flt;
		b = a[27:26];
		hit = a[31:28] == 4'h0 && a >= `EPBD_DRAM_B0_LO && (m[b] || a[25:22] == 4'h0);
		flt = (k == 2'h1 && (a < `EPBD_FULL_FETCH_LO || a > `EPBD_FULL_FETCH_HI))
			|| (k == 2'h2 && (a < `EPBD_COMP_FETCH_LO || a > `EPBD_COMP_FETCH_HI));
		return {hit && !flt, m[b], flt, b};
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One request; with arb set the other processor may hold the DRAM bus
	task automatic op(input logic [31:0] a, input logic [1:0] k, input logic [31:0] r,
		input logic arb);
		logic [4:0] e;
		logic [4:0] e0;
		logic [3:0] ed;
		logic [1:0] ix;
		logic hit;
		logic vld;
		vld = r[31:29] != 3'h0;
		@(posedge sys_clk);
		req <= {vld, a, epbd_pkg::epbd_kind_type'(k), r[0], r[1], r, ~r};
		fetch_word <= {r[15:0], r};
		@(posedge sys_clk);
		#1;
		e = decode(a, cfg.dram_mode, k);
		e0 = decode(a, cfg.dram_mode, 2'h0);
		ix = e0[4] ? e0[1:0] : 2'h0;
		hit = vld && e[4];
		ed = hit && e[3] ? 4'h1 << e[1:0] : 4'h0;
		if (arb)
			chk(dram_bank_select & ~ed, 64'h0);
		else
			chk(dram_bank_select, ed);
		chk(async_bank_select, hit && !e[3] ? 4'h1 << e[1:0] : 4'h0);
		chk(bus_request, hit && e[3]);
		if (vld)
		begin
			chk(fetch_fault, e[2]);
			chk(decode_miss, !e0[4]);
			chk(comp_count, k == 2'h2 && !e[2] ? 2'h3 : 2'h0);
		end
		if (hit)
		begin
			chk(bank_index, e[1:0]);
			chk(bank_offset, a - (e[1:0] == 2'h0 ? 32'h0020_0000 : {4'h0, e[1:0], 26'h0}));
			if (!e[3])
				chk(bank_timing, cfg.async_timing[e[1:0]]);
			else if (!arb)
			begin
				chk(simd_wide, r[0]);
				chk(external_port_data_bus, r[0] ? {r, ~r} : {32'h0, ~r});
			end
		end
		chk(comp_instr, {r[15:0], r});
		chk(dram_timing_out, cfg.dram_timing);
		chk(cfg_error, cfg.clk_ratio < 4'h2 || cfg.dev_mbit > 12'h800
			|| cfg.dram_size_mb[ix] < 9'h020 || cfg.dram_size_mb[ix] > 9'h100);
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog sized well above the roughly 1800 cycles the tests need
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		finish_test();
	end

	initial
	begin
		sys_rst = 1'h1;
		req = '0;
		fetch_word = '0;
		part_en = 1'h0;
		n_errors = 0;
		num_checks = 0;
		seed = 32'h7F69_0618;
		cfg = '0;
		cfg.clk_ratio = `EPBD_RATIO_MIN;
		cfg.dev_mbit = `EPBD_DEV_MBIT_MAX;
		cfg.timeout = 16'hFFFF;
		cfg.lock = 1'h1;
		cfg.dram_timing = 32'hA5C3_0F1E;
		for (int b = 0; b < 4; b++)
		begin
			cfg.dram_size_mb[b] = b[0] ? `EPBD_DRAM_MB_MIN : `EPBD_DRAM_MB_MAX;
			cfg.async_timing[b] = 16'(16'h1111 * (b + 1));
		end
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'h0;
		// Corners of the windows, not the bank 2 and 3 bases or DRAM tops of banks 1 and 2, under all-async, all-DRAM and mixed maps
		foreach (corner[i])
			for (int m = 0; m < 4; m++)
				for (int k = 0; k < 3; k++)
				begin
					@(posedge sys_clk);
					cfg.dram_mode <= 4'h5 * m[1:0];
					op(corner[i], k[1:0], seed | 32'h8000_0000, 1'h0);
					seed = lfsr(seed);
				end
		repeat (300)
		begin
			seed = lfsr(seed);
			@(posedge sys_clk);
			cfg.dram_mode <= seed[7:4];
			op({4'h0, seed[27:0]}, seed[9:8] == 2'h3 ? 2'h0 : seed[9:8], lfsr(seed), 1'h0);
		end
		// Clock ratio and device size outside their limits
		@(posedge sys_clk);
		cfg.clk_ratio <= 4'h1;
		op(32'h0400_0000, 2'h0, seed | 32'h8000_0000, 1'h0);
		@(posedge sys_clk);
		cfg.clk_ratio <= 4'h2;
		cfg.dev_mbit <= 12'h801;
		op(32'h0800_0000, 2'h0, seed | 32'h8000_0000, 1'h0);
		// Bank 2 sized below the smallest legal DRAM bank
		@(posedge sys_clk);
		cfg.dev_mbit <= 12'h800;
		cfg.dram_size_mb[2] <= 9'h01F;
		op(32'h0800_0000, 2'h0, seed | 32'h8000_0000, 1'h0);
		// Shared bus with rotation and a short time-out, the other processor active
		@(posedge sys_clk);
		cfg.dram_size_mb[2] <= `EPBD_DRAM_MB_MAX;
		cfg.dev_mbit <= 12'h800;
		cfg.lock <= 1'h0;
		cfg.rotate <= 1'h1;
		cfg.timeout <= 16'h0004;
		cfg.dram_mode <= 4'hF;
		part_en <= 1'h1;
		repeat (150)
		begin
			seed = lfsr(seed);
			op({4'h0, seed[27:0]}, 2'h0, seed, 1'h1);
		end
		finish_test();
	end
endmodule
